/* design/fdcr_pkg.sv */
// Package for the flash driver configuration register bank.
// Assumes a 10 MHz system clock; all timing counts derive from it.
package fdcr_pkg;

  // Clock rate
  localparam int CLK_HZ  = 10_000_000;
  localparam int CLK_MHZ = 10;

  // Serial port address (7 bits) and register offsets
  localparam logic [6:0] DEV_ADDR       = 7'h67;
  localparam logic [7:0] OFS_PEAK       = 8'h02;
  localparam logic [7:0] OFS_TIMER      = 8'h03;
  localparam logic [7:0] OFS_LOW_SUPPLY = 8'h04;
  localparam logic [7:0] OFS_THERMAL    = 8'h05;
  localparam logic [7:0] OFS_FLASH_CUR  = 8'h06;

  // Reset values, reserved bits included
  localparam logic [7:0] RST_PEAK       = 8'h08;
  localparam logic [7:0] RST_TIMER      = 8'h10;
  localparam logic [7:0] RST_LOW_SUPPLY = 8'hf0;
  localparam logic [7:0] RST_THERMAL    = 8'h14;
  localparam logic [7:0] RST_FLASH_CUR  = 8'h10;

  // Field positions
  localparam int PEAK_LIM_LSB  = 3;
  localparam int STRETCH_BIT   = 2;
  localparam int TIMER_LSB     = 4;
  localparam int AUTOCLR_BIT   = 3;
  localparam int SWFREQ_LSB    = 0;
  localparam int LOWTHR_LSB    = 5;
  localparam int LOWACT_BIT    = 4;
  localparam int THADAPT_BIT   = 7;
  localparam int RAMP_LSB      = 4;
  localparam int HEADROOM_LSB  = 2;
  localparam int DUTY_LSB      = 0;
  localparam int FLCUR_LSB     = 0;

  // Codes
  localparam logic [2:0] LOWTHR_OFF   = 3'h7;
  localparam logic [1:0] MODE_STANDBY = 2'h0;
  localparam logic [1:0] MODE_INDIC   = 2'h1;
  localparam logic [1:0] MODE_ASSIST  = 2'h2;
  localparam logic [1:0] MODE_FLASH   = 2'h3;
  localparam logic [3:0] DUTY_BASE    = 4'h2;

  // Timing: flash step, ramp base step, indicator PWM
  localparam int FLASH_STEP_MS  = 50;
  localparam int FLASH_STEP_CYC = FLASH_STEP_MS * (CLK_HZ / 1000);
  localparam int RAMP_BASE_US   = 8;
  localparam int RAMP_BASE_CYC  = RAMP_BASE_US * CLK_MHZ;
  localparam int PWM_FREQ_HZ    = 31_500;
  localparam int PWM_SLOTS      = 16;
  localparam int PWM_SLOT_CYC   = (CLK_HZ / PWM_FREQ_HZ) / PWM_SLOTS;

  // Decoded configuration handed to the converter
  typedef struct packed {
    logic [1:0] inductor_limit_sel;
    logic       freq_stretch_disable;
    logic [1:0] switch_freq_sel;
    logic [1:0] headroom_threshold;
    logic [2:0] ramp_step_time;
    logic [2:0] low_supply_threshold;
  } fdcr_cfg_t;

  typedef enum logic [3:0] {
    SP_IDLE     = 4'h0,
    SP_ADDR     = 4'h1,
    SP_ACK_ADDR = 4'h2,
    SP_PTR      = 4'h3,
    SP_ACK_PTR  = 4'h4,
    SP_WDATA    = 4'h5,
    SP_ACK_DATA = 4'h6,
    SP_RDATA    = 4'h7,
    SP_RACK     = 4'h8
  } fdcr_sp_st_t;

  typedef enum logic [1:0] {
    FL_IDLE = 2'h0,
    FL_RAMP = 2'h1,
    FL_HOLD = 2'h2
  } fdcr_fl_st_t;

endpackage : fdcr_pkg

/* design/fdcr_top.sv */
// Flash driver configuration bank: serial register port, flash timer,
// current ramp, low-supply and thermal fallback, indicator PWM.
// Assumes the mode register lives outside and reacts to mode_autoclear;
// analog comparator flags and the serial pins arrive asynchronously.
// What this block does
// - Two-bit inductor limit, 1.9A to 4.2A, reset 01, sent to converter
// - Stretch-disable bit, 0 lets frequency stretch below 1MHz, reset 0
// - Four-bit flash duration, 50ms per step, reset 0001
// - Autoclear bit 0 resets mode and enable after flash or torch
// - Two-bit switching frequency, 4MHz down to 1MHz, reset 00
// - Three-bit low-supply threshold from 3V, code 111 disables, reset 111
// - Low supply during flash ramp halts further ramp steps
// - Low supply during flash pulse lowers current until supply recovers
// - Low supply before flash: disabled if action bit 1, else TX current
// - Thermal adapt 1 cuts to TX current at 130C, else off at 150C
// - Three-bit ramp step time, 8us per code step, reset 001
// - Two-bit headroom threshold, 300mV to 750mV, reset 01
// - Indicator mode PWM, 31.5kHz asked, period 304 clocks or about 32.9kHz, duty 2/16 to 5/16
// - Six-bit flash current code, 31.7mA per step, reset 010000
// - Mode field decodes only indicator (PWM) and flash (flash_start); standby and assist do nothing here
// - TX-limited current comes from a separate code, used when TX high
`timescale 1ns/1ps
`default_nettype none

module fdcr_top
#(
  parameter int FLASH_STEP_CYC = fdcr_pkg::FLASH_STEP_CYC
)
(
  input  wire logic               clk_sys,
  input  wire logic               resetn,
  input  wire logic               scl_i,
  input  wire logic               sda_i,
  output logic                    sda_o,
  output logic                    sda_oe_n,
  input  wire logic [1:0]         mode_select,
  input  wire logic               flash_start,
  input  wire logic               flash_stop,
  input  wire logic               torch_end,
  input  wire logic               low_supply_below,
  input  wire logic               over_temp_130,
  input  wire logic               over_temp_150,
  input  wire logic               tx_high,
  input  wire logic [5:0]         tx_current_code,
  output fdcr_pkg::fdcr_cfg_t     cfg,
  output logic [5:0]              led_current_code,
  output logic                    flash_active,
  output logic                    flash_timeout,
  output logic                    mode_autoclear,
  output logic                    indicator_pwm
);

  // Read mux for the serial port; unmapped offsets read as zero
  function automatic logic [7:0] reg_read(input logic [7:0] ofs,
                                          input logic [39:0] regs);
    logic [7:0] v;
    v = 8'h00;
    unique case (ofs)
      fdcr_pkg::OFS_PEAK:       v = regs[7:0];
      fdcr_pkg::OFS_TIMER:      v = regs[15:8];
      fdcr_pkg::OFS_LOW_SUPPLY: v = regs[23:16];
      fdcr_pkg::OFS_THERMAL:    v = regs[31:24];
      fdcr_pkg::OFS_FLASH_CUR:  v = regs[39:32];
      default:                  v = 8'h00;
    endcase
    return v;
  endfunction : reg_read

  // Registers, stored whole so reserved bits read back
  logic [7:0]            peak_r, timer_r, lowsup_r, thermal_r, flcur_r;
  logic [5:0]            sync1_r, sync2_r;
  logic                  scl_d_r, sda_d_r;
  fdcr_pkg::fdcr_sp_st_t sp_st_r;
  logic [3:0]            bit_cnt_r;
  logic [7:0]            shift_r, ptr_r, tx_r;
  logic                  rw_r, drive_low_r;
  fdcr_pkg::fdcr_fl_st_t fl_st_r;
  logic [5:0]            cur_r;
  logic                  pre_low_r;
  logic [15:0]           step_cnt_r;
  logic [31:0]           tmr_cyc_r;
  logic [3:0]            tmr_step_r;
  logic                  timeout_r, autoclr_r;
  logic [8:0]            pwm_cyc_r;
  logic [3:0]            pwm_slot_r;

  // Synchronisers: only the second stage is read below
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn) begin sync1_r <= 6'h3f; sync2_r <= 6'h3f; end
    else
    begin
      sync1_r <= {scl_i, sda_i, low_supply_below, over_temp_130, over_temp_150, tx_high};
      sync2_r <= sync1_r;
    end
  end

  wire scl_s = sync2_r[5];
  wire sda_s = sync2_r[4];
  wire low_s = sync2_r[3];
  wire ot130 = sync2_r[2];
  wire ot150 = sync2_r[1];
  wire tx_s  = sync2_r[0];

  // Field decode
  wire [3:0] duration_sel = timer_r[fdcr_pkg::TIMER_LSB +: 4];
  wire       autoclr_keep = timer_r[fdcr_pkg::AUTOCLR_BIT];
  wire [2:0] low_thr      = lowsup_r[fdcr_pkg::LOWTHR_LSB +: 3];
  wire       low_act_sel  = lowsup_r[fdcr_pkg::LOWACT_BIT];
  wire       th_adapt     = thermal_r[fdcr_pkg::THADAPT_BIT];
  wire [2:0] ramp_sel     = thermal_r[fdcr_pkg::RAMP_LSB +: 3];
  wire [1:0] duty_sel     = thermal_r[fdcr_pkg::DUTY_LSB +: 2];
  wire [5:0] flash_sel    = flcur_r[fdcr_pkg::FLCUR_LSB +: 6];

  // Converter settings come straight from the stored fields
  assign cfg.inductor_limit_sel   = peak_r[fdcr_pkg::PEAK_LIM_LSB +: 2];
  assign cfg.freq_stretch_disable = peak_r[fdcr_pkg::STRETCH_BIT];
  assign cfg.switch_freq_sel      = timer_r[fdcr_pkg::SWFREQ_LSB +: 2];
  assign cfg.headroom_threshold   = thermal_r[fdcr_pkg::HEADROOM_LSB +: 2];
  assign cfg.ramp_step_time       = ramp_sel;
  assign cfg.low_supply_threshold = low_thr;

  // Serial bus conditions, sampled on the synchronised lines
  wire scl_rise = scl_s & ~scl_d_r;
  wire scl_fall = ~scl_s & scl_d_r;
  wire start_c  = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire stop_c   = scl_s & scl_d_r & ~sda_d_r & sda_s;
  wire byte_done = (bit_cnt_r == 4'h8);
  wire [7:0] rd_byte = reg_read(ptr_r, {flcur_r, thermal_r, lowsup_r, timer_r, peak_r});
  wire wr_en = scl_fall & (sp_st_r == fdcr_pkg::SP_WDATA) & byte_done;

  // Open drain: only ever pulls low
  assign sda_o    = 1'b0;
  assign sda_oe_n = ~drive_low_r;

  // Serial protocol sequencer; a stop or restart always returns to idle/address
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      sp_st_r <= fdcr_pkg::SP_IDLE; bit_cnt_r <= 4'h0; shift_r <= 8'h00;
      ptr_r <= 8'h00; tx_r <= 8'h00; rw_r <= 1'b0; drive_low_r <= 1'b0;
      scl_d_r <= 1'b1; sda_d_r <= 1'b1;
    end
    else
    begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
      if (start_c)
      begin
        sp_st_r <= fdcr_pkg::SP_ADDR; bit_cnt_r <= 4'h0; drive_low_r <= 1'b0;
      end
      else if (stop_c)
      begin
        sp_st_r <= fdcr_pkg::SP_IDLE; drive_low_r <= 1'b0;
      end
      else if (scl_rise && sp_st_r != fdcr_pkg::SP_IDLE)
      begin
        shift_r   <= {shift_r[6:0], sda_s};
        bit_cnt_r <= bit_cnt_r + 4'h1;
        if (sp_st_r == fdcr_pkg::SP_RACK && sda_s)
          sp_st_r <= fdcr_pkg::SP_IDLE;                      // Host NACK ends the read
      end
      else if (scl_fall)
      begin
        unique case (sp_st_r)
          fdcr_pkg::SP_IDLE: ;
          fdcr_pkg::SP_ADDR:
            if (byte_done)
            begin
              if (shift_r[7:1] == fdcr_pkg::DEV_ADDR)
              begin
                sp_st_r <= fdcr_pkg::SP_ACK_ADDR; rw_r <= shift_r[0]; drive_low_r <= 1'b1;
              end
              else sp_st_r <= fdcr_pkg::SP_IDLE;
            end
          fdcr_pkg::SP_ACK_ADDR:
            if (rw_r)
            begin
              sp_st_r <= fdcr_pkg::SP_RDATA; tx_r <= rd_byte;
              drive_low_r <= ~rd_byte[7]; bit_cnt_r <= 4'h0;
            end
            else
            begin
              sp_st_r <= fdcr_pkg::SP_PTR; drive_low_r <= 1'b0; bit_cnt_r <= 4'h0;
            end
          fdcr_pkg::SP_PTR:
            if (byte_done)
            begin
              ptr_r <= shift_r; sp_st_r <= fdcr_pkg::SP_ACK_PTR; drive_low_r <= 1'b1;
            end
          fdcr_pkg::SP_ACK_PTR, fdcr_pkg::SP_ACK_DATA:
          begin
            sp_st_r <= fdcr_pkg::SP_WDATA; drive_low_r <= 1'b0; bit_cnt_r <= 4'h0;
          end
          fdcr_pkg::SP_WDATA:
            if (byte_done)
            begin
              ptr_r <= ptr_r + 8'h01; sp_st_r <= fdcr_pkg::SP_ACK_DATA; drive_low_r <= 1'b1;
            end
          fdcr_pkg::SP_RDATA:
            if (byte_done)
            begin
              ptr_r <= ptr_r + 8'h01; sp_st_r <= fdcr_pkg::SP_RACK; drive_low_r <= 1'b0;
            end
            else drive_low_r <= ~tx_r[3'd7 - bit_cnt_r[2:0]];
          fdcr_pkg::SP_RACK:
          begin
            sp_st_r <= fdcr_pkg::SP_RDATA; tx_r <= rd_byte;
            drive_low_r <= ~rd_byte[7]; bit_cnt_r <= 4'h0;
          end
          default: sp_st_r <= fdcr_pkg::SP_IDLE;
        endcase
      end
    end
  end

  // Register writes; reserved bits are stored but drive nothing
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      peak_r <= fdcr_pkg::RST_PEAK; timer_r <= fdcr_pkg::RST_TIMER;
      lowsup_r <= fdcr_pkg::RST_LOW_SUPPLY; thermal_r <= fdcr_pkg::RST_THERMAL;
      flcur_r <= fdcr_pkg::RST_FLASH_CUR;
    end
    else if (wr_en)
    begin
      if (ptr_r == fdcr_pkg::OFS_PEAK)       peak_r    <= shift_r;
      if (ptr_r == fdcr_pkg::OFS_TIMER)      timer_r   <= shift_r;
      if (ptr_r == fdcr_pkg::OFS_LOW_SUPPLY) lowsup_r  <= shift_r;
      if (ptr_r == fdcr_pkg::OFS_THERMAL)    thermal_r <= shift_r;
      if (ptr_r == fdcr_pkg::OFS_FLASH_CUR)  flcur_r   <= shift_r;
    end
  end

  // Flash control decode; a threshold code of all ones masks the comparator
  wire low_on      = low_s & (low_thr != fdcr_pkg::LOWTHR_OFF);
  wire th_cut      = th_adapt & ot130;
  wire th_off      = ~th_adapt & ot150;
  wire use_tx      = tx_s | th_cut | pre_low_r;
  wire [5:0] target = use_tx ? tx_current_code : flash_sel;
  wire [15:0] step_len = 16'((32'(ramp_sel) + 32'd1) * 32'(fdcr_pkg::RAMP_BASE_CYC));
  wire step_tick   = (step_cnt_r == step_len - 16'h1);
  wire tmr_tick    = (tmr_cyc_r == 32'(FLASH_STEP_CYC - 1));
  wire tmr_done    = tmr_tick & (tmr_step_r == duration_sel);
  wire fl_on       = (fl_st_r != fdcr_pkg::FL_IDLE);
  wire fl_end      = fl_on & (tmr_done | flash_stop | th_off);
  wire go_flash    = flash_start & (mode_select == fdcr_pkg::MODE_FLASH);
  wire refuse      = low_on & low_act_sel;

  // Flash sequencer: ramp up, hold, fold back on low supply or heat
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      fl_st_r <= fdcr_pkg::FL_IDLE; cur_r <= 6'h00; pre_low_r <= 1'b0;
      step_cnt_r <= 16'h0000; tmr_cyc_r <= 32'h0; tmr_step_r <= 4'h0;
    end
    else
    begin
      step_cnt_r <= (step_tick || !fl_on) ? 16'h0000 : step_cnt_r + 16'h0001;
      if (fl_on && !tmr_tick) tmr_cyc_r <= tmr_cyc_r + 32'h1;
      else tmr_cyc_r <= 32'h0;
      if (!fl_on) tmr_step_r <= 4'h0;
      else if (tmr_tick) tmr_step_r <= tmr_step_r + 4'h1;
      unique case (fl_st_r)
        fdcr_pkg::FL_IDLE:
          if (go_flash && !refuse)
          begin
            fl_st_r <= fdcr_pkg::FL_RAMP; cur_r <= 6'h00; pre_low_r <= low_on;
          end
        fdcr_pkg::FL_RAMP:
          if (fl_end) begin fl_st_r <= fdcr_pkg::FL_IDLE; cur_r <= 6'h00; end
          else if (cur_r > target) cur_r <= target;
          // A supply already low at start still ramps, but only to the TX current
          else if (low_on && !pre_low_r) fl_st_r <= fdcr_pkg::FL_HOLD;
          else if (step_tick)
          begin
            if (cur_r < target) cur_r <= cur_r + 6'h01;
            else fl_st_r <= fdcr_pkg::FL_HOLD;
          end
        fdcr_pkg::FL_HOLD:
          if (fl_end) begin fl_st_r <= fdcr_pkg::FL_IDLE; cur_r <= 6'h00; end
          else if (cur_r > target) cur_r <= target;
          else if (step_tick && low_on && cur_r != 6'h00)
            cur_r <= cur_r - 6'h01;
        default: fl_st_r <= fdcr_pkg::FL_IDLE;
      endcase
    end
  end

  // Event pulses; the mode register outside reacts to the autoclear pulse
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn) begin timeout_r <= 1'b0; autoclr_r <= 1'b0; end
    else
    begin
      timeout_r <= fl_on & tmr_done;
      autoclr_r <= (fl_end | torch_end) & ~autoclr_keep;
    end
  end

  // Indicator PWM: 16 slots per period, high for code plus two slots
  wire pwm_slot_end = (pwm_cyc_r == 9'(fdcr_pkg::PWM_SLOT_CYC - 1));
  wire pwm_level = (mode_select == fdcr_pkg::MODE_INDIC)
                   & (pwm_slot_r < (fdcr_pkg::DUTY_BASE + {2'b00, duty_sel}));
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      pwm_cyc_r <= 9'h000; pwm_slot_r <= 4'h0; indicator_pwm <= 1'b0;
    end
    else
    begin
      pwm_cyc_r     <= pwm_slot_end ? 9'h000 : pwm_cyc_r + 9'h001;
      if (pwm_slot_end) pwm_slot_r <= pwm_slot_r + 4'h1;
      indicator_pwm <= pwm_level;
    end
  end

  assign led_current_code = cur_r;
  assign flash_active     = fl_on;
  assign flash_timeout    = timeout_r;
  assign mode_autoclear   = autoclr_r;

endmodule : fdcr_top

`default_nettype wire

/* bench/fdcr_monitor.sv */
// Checker for the flash driver configuration bank, bound to fdcr_top.
// Sees only top ports; serial timing is judged by the bench.
`timescale 1ns/1ps
`default_nettype none
module fdcr_monitor
#(
  parameter int FLASH_STEP_CYC = 200
)
(
  input wire logic                clk_sys,
  input wire logic                resetn,
  input wire logic [1:0]          mode_select,
  input wire logic                flash_start,
  input wire logic                flash_stop,
  input wire logic                low_supply_below,
  input wire logic                over_temp_150,
  input wire fdcr_pkg::fdcr_cfg_t cfg,
  input wire logic [5:0]          led_current_code,
  input wire logic                flash_active,
  input wire logic                flash_timeout,
  input wire logic                mode_autoclear,
  input wire logic                indicator_pwm
);
  logic [11:0] gap_r;
  logic [5:0]  code_r;
  logic [11:0] iv;
  logic        pre_low_r;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Ramp interval; tolerance covers the unknown one-edge skew of the counter
  assign iv = 12'((cfg.ramp_step_time + 3'h1) * 80);
  // Cycles since the current code last moved
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      gap_r  <= 12'h000;
      code_r <= 6'h00;
      pre_low_r <= 1'b0;
    end
    else
    begin
      code_r <= led_current_code;
      // Supply level seen just before the flash; a low start ramps to the TX code
      pre_low_r <= flash_active ? pre_low_r : low_supply_below;
      gap_r  <= (!flash_active || code_r != led_current_code) ? 12'h000 : gap_r + 12'h001;
    end
  end
  property p_reset_cfg;
    $rose(resetn) |-> cfg == 13'h084f;
  endproperty
  a_reset_cfg: assert property (p_reset_cfg) else $error("cfg not at reset value");
  property p_start_taken;
    (!low_supply_below && !over_temp_150) [*4] ##0
      (flash_start && mode_select == 2'h3 && !flash_active && !flash_stop) |=> flash_active;
  endproperty
  a_start_taken: assert property (p_start_taken) else $error("flash not started");
  property p_idle_zero;
    !flash_active |-> led_current_code == 6'h00;
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("current while idle");
  property p_ramp_gap;
    flash_active && $past(flash_active) && led_current_code > code_r
      |-> gap_r + 12'h002 >= iv && gap_r <= iv + 12'h002;
  endproperty
  a_ramp_gap: assert property (p_ramp_gap) else $error("ramp step interval wrong");
  property p_timeout_pulse;
    flash_timeout |-> !flash_active ##1 !flash_timeout;
  endproperty
  a_timeout_pulse: assert property (p_timeout_pulse) else $error("timeout pulse bad");
  property p_autoclr_pulse;
    mode_autoclear |=> !mode_autoclear;
  endproperty
  a_autoclr_pulse: assert property (p_autoclr_pulse) else $error("autoclear too long");
  property p_pwm_off;
    (mode_select != 2'h1) [*4] |-> !indicator_pwm;
  endproperty
  a_pwm_off: assert property (p_pwm_off) else $error("pwm outside indicator mode");
  property p_stop_ends;
    flash_stop && flash_active |-> ##[1:2] !flash_active;
  endproperty
  a_stop_ends: assert property (p_stop_ends) else $error("stop did not end flash");
  property p_low_hold;
    (low_supply_below && flash_active && !pre_low_r && cfg.low_supply_threshold != 3'h7) [*5]
      |-> led_current_code <= $past(led_current_code);
  endproperty
  a_low_hold: assert property (p_low_hold) else $error("current rose on low supply");
  c_timeout: cover property (flash_timeout);
  c_autoclr: cover property (mode_autoclear);
  c_pwm: cover property ($rose(indicator_pwm));
endmodule : fdcr_monitor
bind fdcr_top fdcr_monitor #(.FLASH_STEP_CYC(FLASH_STEP_CYC)) fdcr_monitor_inst (
  .clk_sys(clk_sys), .resetn(resetn), .mode_select(mode_select),
  .flash_start(flash_start), .flash_stop(flash_stop),
  .low_supply_below(low_supply_below), .over_temp_150(over_temp_150), .cfg(cfg),
  .led_current_code(led_current_code), .flash_active(flash_active),
  .flash_timeout(flash_timeout), .mode_autoclear(mode_autoclear),
  .indicator_pwm(indicator_pwm));
`default_nettype wire

/* bench/fdcr_host_model.sv */
// Serial host for the configuration bank: register writes and reads.
// Assumes SDA has a pull-up; each SCL half lasts 6 clocks.
`timescale 1ns/1ps
`default_nettype none
module fdcr_host_model
(
  input  wire logic clk_sys,
  output var logic  scl,
  output var logic  sda,
  input  wire logic sda_line
);
  logic nack_seen;
  // Idle bus: clock stands high, data released
  initial
  begin
    scl = 1'b1;
    sda = 1'b1;
    nack_seen = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick
  // Data moves only while SCL is low; sampled late in the high half
  task automatic bit_io(input logic b, output logic s);
    scl <= 1'b0;
    tick(3);
    sda <= b;
    tick(3);
    scl <= 1'b1;
    tick(6);
    s = sda_line;
  endtask : bit_io
  task automatic start_cond();
    scl <= 1'b0;
    tick(3);
    sda <= 1'b1;
    tick(3);
    scl <= 1'b1;
    tick(3);
    sda <= 1'b0;
    tick(3);
  endtask : start_cond
  task automatic stop_cond();
    scl <= 1'b0;
    tick(3);
    sda <= 1'b0;
    tick(3);
    scl <= 1'b1;
    tick(3);
    sda <= 1'b1;
    tick(6);
  endtask : stop_cond
  task automatic byte_out(input logic [7:0] d);
    logic a;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], a);
    bit_io(1'b1, a);
    if (a)
      nack_seen = 1'b1;
  endtask : byte_out
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    start_cond();
    byte_out({fdcr_pkg::DEV_ADDR, 1'b0});
    byte_out(ofs);
    byte_out(d);
    stop_cond();
  endtask : wr
  // Pointer write, repeated start, one byte read, closing NACK
  task automatic rd(input logic [7:0] ofs, output logic [7:0] d);
    logic a;
    start_cond();
    byte_out({fdcr_pkg::DEV_ADDR, 1'b0});
    byte_out(ofs);
    start_cond();
    byte_out({fdcr_pkg::DEV_ADDR, 1'b1});
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(1'b1, a);
    stop_cond();
  endtask : rd
endmodule : fdcr_host_model
`default_nettype wire

/* bench/test_flash_driver_config_regs.sv */
// Testbench for the flash driver configuration bank.
// Assumes the host model on the serial pins and a 200-cycle flash step.
`timescale 1ns/1ps
`default_nettype none
module test_flash_driver_config_regs;
  logic                clk_sys, resetn, flash_start, flash_stop, torch_end;
  logic                low_supply_below, over_temp_130, over_temp_150, tx_high;
  logic [1:0]          mode_select;
  logic [5:0]          tx_current_code, pk;
  wire logic           scl, sda_h, sda_o, sda_oe_n, sda_line, flash_active;
  wire logic           flash_timeout, mode_autoclear, indicator_pwm;
  wire logic [5:0]     led_current_code;
  fdcr_pkg::fdcr_cfg_t cfg;
  int                  err_total, checks_done, cyc, ac_cnt, to_cnt, len;
  // Open-drain data line with pull-up
  assign sda_line = sda_h & (sda_oe_n | sda_o);
  fdcr_top #(.FLASH_STEP_CYC(200)) fdcr_top_inst (.clk_sys(clk_sys), .resetn(resetn),
    .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .mode_select(mode_select), .flash_start(flash_start), .flash_stop(flash_stop),
    .torch_end(torch_end), .low_supply_below(low_supply_below),
    .over_temp_130(over_temp_130), .over_temp_150(over_temp_150), .tx_high(tx_high),
    .tx_current_code(tx_current_code), .cfg(cfg), .led_current_code(led_current_code),
    .flash_active(flash_active), .flash_timeout(flash_timeout),
    .mode_autoclear(mode_autoclear), .indicator_pwm(indicator_pwm));
  fdcr_host_model fdcr_host_model_inst (.clk_sys(clk_sys), .scl(scl), .sda(sda_h),
    .sda_line(sda_line));
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // Pulse counters and hang guard
  always @(posedge clk_sys)
  begin
    cyc++;
    ac_cnt += (mode_autoclear === 1'b1);
    to_cnt += (flash_timeout === 1'b1);
    if (cyc == 60000)
    begin
      err_total++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
    checks_done++;
    if (got !== ex)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  task automatic reg_is(input logic [7:0] ofs, input logic [7:0] ex);
    logic [7:0] v;
    fdcr_host_model_inst.rd(ofs, v);
    chk("register", {ofs, ex}, {ofs, v});
  endtask : reg_is
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    fdcr_host_model_inst.wr(ofs, d);
  endtask : wr
  // One flash; optional early stop and low-supply toggle, by active cycle
  task automatic run_flash(input int stop_at, input int low_until);
    len = 0;
    pk = 6'h00;
    flash_start <= 1'b1;
    @(posedge clk_sys);
    flash_start <= 1'b0;
    for (int i = 0; i < 2000; i++)
    begin
      @(posedge clk_sys);
      if (flash_active === 1'b1)
      begin
        len++;
        if (led_current_code > pk)
          pk = led_current_code;
      end
      else if (len > 0 || i > 12)
        break;
      flash_stop <= (len == stop_at);
      if (len == low_until)
        low_supply_below <= ~low_supply_below;
    end
    repeat (4) @(posedge clk_sys);
  endtask : run_flash
  task automatic t_reset();
    chk("cfg", 16'h084f, 16'(cfg));
    reg_is(8'h02, 8'h08);
    reg_is(8'h03, 8'h10);
    reg_is(8'h04, 8'hf0);
    reg_is(8'h05, 8'h14);
    reg_is(8'h06, 8'h10);
  endtask : t_reset
  task automatic t_regs();
    wr(8'h02, 8'hff);
    wr(8'h03, 8'h13);
    wr(8'h04, 8'h10);
    wr(8'h05, 8'h8c);
    wr(8'h06, 8'hc3);
    reg_is(8'h02, 8'hff);
    reg_is(8'h06, 8'hc3);
    reg_is(8'h07, 8'h00);
    chk("cfg", 16'h1fc0, 16'(cfg));
    chk("nack", 16'h0000, 16'(fdcr_host_model_inst.nack_seen));
  endtask : t_regs
  task automatic t_flash();
    run_flash(-1, -1);
    chk("flash length", 16'd400, 16'(len));
    chk("peak current", 16'h0003, 16'(pk));
    tx_high <= 1'b1;
    run_flash(-1, -1);
    chk("tx current", 16'h0002, 16'(pk));
    tx_high <= 1'b0;
    over_temp_130 <= 1'b1;
    run_flash(-1, -1);
    chk("thermal current", 16'h0002, 16'(pk));
    over_temp_130 <= 1'b0;
    run_flash(50, -1);
    chk("stopped early", 16'h0001, 16'(len < 60));
    chk("timeouts", 16'd3, 16'(to_cnt));
    chk("autoclears", 16'd4, 16'(ac_cnt));
  endtask : t_flash
  task automatic t_low();
    low_supply_below <= 1'b1;
    // Let the comparator level pass the synchroniser before the start
    repeat (4) @(posedge clk_sys);
    run_flash(-1, -1);
    chk("refused length", 16'd0, 16'(len));
    wr(8'h04, 8'h00);
    low_supply_below <= 1'b1;
    run_flash(-1, 150);
    chk("low start current", 16'h0002, 16'(pk));
    run_flash(-1, 200);
    chk("low during ramp", 16'h0002, 16'(pk));
    low_supply_below <= 1'b0;
  endtask : t_low
  task automatic t_autoclr();
    int a0;
    wr(8'h03, 8'h1b);
    a0 = ac_cnt;
    torch_end <= 1'b1;
    @(posedge clk_sys);
    torch_end <= 1'b0;
    run_flash(-1, -1);
    chk("autoclear kept", 16'(a0), 16'(ac_cnt));
    wr(8'h03, 8'h13);
    torch_end <= 1'b1;
    @(posedge clk_sys);
    torch_end <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk("autoclear torch", 16'(a0 + 1), 16'(ac_cnt));
  endtask : t_autoclr
  task automatic t_hot();
    wr(8'h05, 8'h0c);
    over_temp_150 <= 1'b1;
    repeat (5) @(posedge clk_sys);
    run_flash(-1, -1);
    chk("hot shutdown", 16'h0001, 16'(len < 10));
    over_temp_150 <= 1'b0;
  endtask : t_hot
  // High samples over three whole periods do not depend on phase
  task automatic t_pwm();
    int hi;
    mode_select <= 2'h1;
    run_flash(-1, -1);
    chk("flash in indicator mode", 16'd0, 16'(len));
    for (int d = 0; d < 4; d++)
    begin
      wr(8'h05, 8'h0c | 8'(d));
      repeat (400) @(posedge clk_sys);
      hi = 0;
      repeat (912) @(posedge clk_sys) hi += (indicator_pwm === 1'b1);
      chk("pwm high", 16'(3 * (2 + d) * 19), 16'(hi));
    end
    mode_select <= 2'h3;
  endtask : t_pwm
  initial
  begin
    {resetn, flash_start, flash_stop, torch_end, low_supply_below} = 5'h00;
    {over_temp_130, over_temp_150, tx_high} = 3'h0;
    mode_select = 2'h3;
    tx_current_code = 6'h02;
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    t_reset();
    t_regs();
    t_flash();
    t_low();
    t_autoclr();
    t_hot();
    t_pwm();
    results();
  end
endmodule : test_flash_driver_config_regs
`default_nettype wire
